/* common/clr_pkg.sv */
// constants and types shared by the converter link control register bank
package clr_pkg;
   // ***********************************************
   // serial port framing
   // ***********************************************
   localparam int unsigned ADDR_W    = 15;       // register address bits
   localparam int unsigned DATA_W    = 8;        // register data bits
   localparam int unsigned SHIFT_W   = 16;       // command plus address bits
   localparam logic [4:0] CNT_ADDR_LAST  = 5'h0f; // rising edge that ends the address
   localparam logic [4:0] CNT_DATA_FIRST = 5'h10; // count once read data is presented
   localparam logic [4:0] CNT_DATA_LAST  = 5'h17; // rising edge that ends the frame

   // ***********************************************
   // register offsets
   // ***********************************************
   localparam logic [14:0] ADDR_DITHER    = 15'h009d; // dither_control
   localparam logic [14:0] ADDR_LSB_CTRL  = 15'h0160; // sample_lsb_control
   localparam logic [14:0] ADDR_LINK_EN   = 15'h0200; // link_subsystem_enable
   localparam logic [14:0] ADDR_LINK_MODE = 15'h0201; // link_mode_select

   // ***********************************************
   // field positions and reset values
   // ***********************************************
   localparam int unsigned DITH_EN_BIT   = 0;   // dither_enable_bit
   localparam int unsigned DITH_AMP_BIT  = 1;   // dither_amplitude_select
   localparam int unsigned DITH_ERR_BIT  = 2;   // dither_rounding_select
   localparam int unsigned DITH_W        = 3;   // defined dither bits
   localparam int unsigned MARKER_BIT    = 0;   // marker_on_lsb_enable
   localparam int unsigned LINK_EN_BIT   = 0;   // link_enable_bit
   localparam int unsigned MODE_W        = 6;   // link_output_mode width
   localparam logic [2:0] RST_DITHER     = 3'h0;
   localparam logic       RST_MARKER     = 1'h0;
   localparam logic       RST_LINK_EN    = 1'h1;
   localparam logic [5:0] RST_MODE       = 6'h00;

   // ***********************************************
   // sample path and link timing
   // ***********************************************
   localparam int unsigned CONV_W   = 12;        // converter sample width
   localparam int unsigned LINK_N   = 16;        // link sample field width
   localparam int unsigned TS_LAT   = 4;         // pin to filtered marker, in cycles
   localparam logic [4:0]  LMFC_LAST = 5'h1f;    // multiframe counter end (32 frames)
   localparam logic [1:0]  ILA_CS_VALUE = 2'h0;  // control bits advertised in alignment data

   // serial port phase, gray along idle -> address -> data
   typedef enum logic [1:0] {
      CLR_IDLE = 2'b00,
      CLR_ADDR = 2'b01,
      CLR_DATA = 2'b11
   } clr_phase_t;
endpackage

/* rtl/clr_marker_insert.sv */
// timestamp marker insertion on the lsb of the link sample field
`timescale 1ns/100ps
module clr_marker_insert (
   input  wire logic        i_mclk,             // sample clock
   input  wire logic        i_rst_n,            // synchronised reset, active low
   input  wire logic        i_ts_pin,           // timestamp pin, asynchronous
   input  wire logic [11:0] i_conv_sample,      // converter sample
   input  wire logic        i_marker_enable,    // marker_on_lsb_enable
   input  wire logic        i_receiver_enable,  // marker_receiver_enable
   output logic [15:0]      o_link_sample       // link sample field
);
   // ***********************************************
   // timestamp synchroniser
   // ***********************************************
   logic s1, s2, s3, ts_q;                       // stages and agreed level
   // ts_q moves four edges after the pin; the sample line below matches that
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         ts_q <= 1'b0;
      end else begin
         s1 <= i_ts_pin;
         s2 <= s1;
         s3 <= s2;
         ts_q <= (s2 == s3) ? s3 : ts_q;
      end
   end

   // ***********************************************
   // latency matched sample line
   // ***********************************************
   logic [11:0] dly [0:clr_pkg::TS_LAT-1];       // sample delay stages
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int i = 0; i < clr_pkg::TS_LAT; i++) dly[i] <= 12'h000;
      end else begin
         dly[0] <= i_conv_sample;                 // R5
         for (int i = 1; i < clr_pkg::TS_LAT; i++) dly[i] <= dly[i-1];
      end
   end

   // marker is dropped while the pin receiver is off
   wire        marker_bit = ts_q & i_receiver_enable;  // R6
   // converter msb-aligned; the pad below keeps the converter lsb intact
   wire [15:0] field = {dly[clr_pkg::TS_LAT-1], {(clr_pkg::LINK_N - clr_pkg::CONV_W){1'b0}}};
   wire [15:0] next_sample = i_marker_enable ? {field[15:1], marker_bit} : field; // R4 R7

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) o_link_sample <= 16'h0000;
      else o_link_sample <= next_sample;
   end

   // ***********************************************
   // checks
   // ***********************************************
   property p_sample_latency;
      @(posedge i_mclk) disable iff (!i_rst_n)
      $past(i_rst_n, 5) |-> o_link_sample[15:4] == $past(i_conv_sample, 5);
   endproperty
   a_sample_latency: assert property (p_sample_latency) else $error("sample latency wrong"); // R5

   property p_lsb_kept;
      @(posedge i_mclk) disable iff (!i_rst_n)
      $past(i_rst_n, 5) && $past(i_marker_enable) |-> o_link_sample[4] == $past(i_conv_sample[0], 5);
   endproperty
   a_lsb_kept: assert property (p_lsb_kept) else $error("converter lsb overwritten"); // R7

   property p_marker_on_lsb;
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_marker_enable && i_receiver_enable && s3 && s2 ##1 $stable(i_marker_enable)
         |=> o_link_sample[0];
   endproperty
   a_marker_on_lsb: assert property (p_marker_on_lsb) else $error("marker missing on lsb"); // R4

   property p_no_marker;
      @(posedge i_mclk) disable iff (!i_rst_n)
      !i_marker_enable |=> o_link_sample[3:0] == 4'h0;
   endproperty
   a_no_marker: assert property (p_no_marker) else $error("marker present while off"); // R4
endmodule

/* rtl/clr_spi_slave.sv */
// serial programming port slave: 24-bit frames, read/write flag, 15-bit address, 8-bit data
`timescale 1ns/100ps
module clr_spi_slave (
   input  wire logic        i_mclk,    // register clock
   input  wire logic        i_rst_n,   // synchronised reset, active low
   input  wire logic        i_sclk,    // serial clock pin
   input  wire logic        i_scs_n,   // chip select pin, active low
   input  wire logic        i_sdi,     // serial data in pin
   input  wire logic [7:0]  i_rdata,   // read data for o_addr
   output logic             o_sdo,     // serial data out
   output logic             o_sdo_oe,  // high while driving sdo
   output logic             o_wr_stb,  // one-cycle write strobe
   output logic [14:0]      o_addr,    // frame address
   output logic [7:0]       o_wdata    // write data
);
   // ***********************************************
   // pin synchronisers
   // ***********************************************
   logic [2:0]  s1, s2, s3, filt;        // sclk, cs_n, sdi stages
   logic        sclk_d;                  // previous filtered sclk
   logic [2:0]  next_filt;               // agreed value
   // a pin change counts only once stages two and three agree
   assign next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);

   // s1 feeds s2 only; reset idles cs high and sclk low
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1 <= 3'h2;
         s2 <= 3'h2;
         s3 <= 3'h2;
         filt <= 3'h2;
         sclk_d <= 1'b0;
      end else begin
         s1 <= {i_sclk, i_scs_n, i_sdi};
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
         sclk_d <= filt[2];
      end
   end

   wire sclk_rise = filt[2] & ~sclk_d;            // sample edge
   wire sclk_fall = ~filt[2] & sclk_d;            // launch edge
   wire cs_n_f    = filt[1];                      // filtered select
   wire sdi_f     = filt[0];                      // filtered data

   // ***********************************************
   // frame decoder
   // ***********************************************
   clr_pkg::clr_phase_t phase;                    // frame phase
   logic [4:0]          cnt;                      // bits taken
   logic [15:0]         shreg;                    // incoming bits
   logic                is_read;                  // frame is a read
   logic                rd_load;                  // load read data next
   logic [7:0]          tx;                       // outgoing bits
   wire  [15:0]         shift_next = {shreg[14:0], sdi_f};
   wire                 take = sclk_rise && (cnt <= clr_pkg::CNT_DATA_LAST);

   // extra clocks past the frame are ignored until select rises
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase <= clr_pkg::CLR_IDLE;
         cnt <= 5'h00;
         shreg <= 16'h0000;
         is_read <= 1'b0;
         rd_load <= 1'b0;
         o_wr_stb <= 1'b0;
         o_addr <= 15'h0000;
         o_wdata <= 8'h00;
      end else begin
         o_wr_stb <= 1'b0;
         rd_load <= 1'b0;
         if (cs_n_f) begin
            phase <= clr_pkg::CLR_IDLE;
            cnt <= 5'h00;
         end else if (take) begin
            shreg <= shift_next;
            cnt <= cnt + 5'h01;
            if (cnt == clr_pkg::CNT_ADDR_LAST) begin
               phase <= clr_pkg::CLR_DATA;
               o_addr <= shift_next[14:0];
               is_read <= shift_next[15];
               rd_load <= shift_next[15];
            end else if (phase == clr_pkg::CLR_IDLE) begin
               phase <= clr_pkg::CLR_ADDR;
            end
            if (cnt == clr_pkg::CNT_DATA_LAST && !is_read) begin
               o_wr_stb <= 1'b1;
               o_wdata <= shift_next[7:0];
            end
         end else if (phase == clr_pkg::CLR_IDLE) begin
            phase <= clr_pkg::CLR_ADDR;
         end
      end
   end

   // read data shifts out msb first on falling sclk, first bit held until bit 17
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tx <= 8'h00;
      end else if (rd_load) begin
         tx <= i_rdata;
      end else if (sclk_fall && phase == clr_pkg::CLR_DATA && cnt > clr_pkg::CNT_DATA_FIRST) begin
         tx <= {tx[6:0], 1'b0};
      end
   end

   assign o_sdo    = tx[7];
   assign o_sdo_oe = is_read && !cs_n_f && (phase == clr_pkg::CLR_DATA);
endmodule

/* rtl/clr_top.sv */
// converter link control register bank: dither, lsb marker, link enable and output mode
`timescale 1ns/100ps
// Behaviour
// R1: rounding select: 0 hurts snr, 1 dc/spurs
// R2: amplitude select: 0 small dither, 1 large
// R3: dither enable bit 0, reset off
// R4: marker enable puts timestamp on sample lsb
// R5: timestamp latency equals sample latency
// R6: software also enables marker receiver
// R7: marker at field lsb, converter lsb kept
// R8: alignment data always advertises zero control bits
// R9: link enable bit, reset value one
// R10: link off: reset, serializers down, clocks gated
// R11: link off holds multiframe counter, sysref ignored
// R12: software disables link before other link changes
// R13: software enables calibration before enabling link
// R14: software disables link before disabling calibration
// R15: six-bit output mode field, reset zero
// R16: mode changed only with link, calibration off
// R17: reserved bits written only as zero
module clr_top (
   input  wire logic        i_mclk,                   // 200 MHz register clock
   input  wire logic        i_resetn,                 // asynchronous reset, active low
   input  wire logic        i_sclk,                   // serial clock pin
   input  wire logic        i_scs_n,                  // serial select pin, active low
   input  wire logic        i_sdi,                    // serial data in pin
   output logic             o_sdo,                    // serial data out
   output logic             o_sdo_oe,                 // sdo drive enable
   input  wire logic        i_sysref,                 // sysref pin
   input  wire logic        i_timestamp,              // timestamp pin
   input  wire logic [11:0] i_conv_sample,            // converter sample
   input  wire logic        i_marker_receiver_enable, // timestamp receiver on
   output logic [15:0]      o_link_sample,            // link sample field
   output logic             o_dither_enable,          // dither on
   output logic             o_dither_amplitude,       // large dither
   output logic             o_dither_rounding,        // rounding error to dc/spurs
   output logic [5:0]       o_link_mode,              // link output mode
   output logic             o_link_rst_n,             // link block out of reset
   output logic             o_serializer_pd,          // serializers powered down
   output logic             o_link_clk_en,            // link clock gate open
   output logic             o_lmfc_boundary,          // multiframe boundary pulse
   output logic [1:0]       o_ila_cs                  // advertised control bits
);
   // ***********************************************
   // reset release
   // ***********************************************
   logic rst_meta;                                    // first release stage
   logic rst_n;                                       // design reset

   // assert at once, release after two clean edges
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ***********************************************
   // serial port
   // ***********************************************
   logic        wr_stb;                               // write strobe
   logic [14:0] addr;                                 // frame address
   logic [7:0]  wdata;                                // write data
   logic [7:0]  rdata;                                // read mux

   clr_spi_slave u_spi (
      .i_mclk   (i_mclk),
      .i_rst_n  (rst_n),
      .i_sclk   (i_sclk),
      .i_scs_n  (i_scs_n),
      .i_sdi    (i_sdi),
      .i_rdata  (rdata),
      .o_sdo    (o_sdo),
      .o_sdo_oe (o_sdo_oe),
      .o_wr_stb (wr_stb),
      .o_addr   (addr),
      .o_wdata  (wdata)
   );

   // ***********************************************
   // register decode
   // ***********************************************
   wire hit_dither = (addr == clr_pkg::ADDR_DITHER);
   wire hit_lsb    = (addr == clr_pkg::ADDR_LSB_CTRL);
   wire hit_link   = (addr == clr_pkg::ADDR_LINK_EN);
   wire hit_mode   = (addr == clr_pkg::ADDR_LINK_MODE);
   wire wr_dither  = wr_stb & hit_dither;
   wire wr_lsb     = wr_stb & hit_lsb;
   wire wr_link    = wr_stb & hit_link;
   wire wr_mode    = wr_stb & hit_mode;

   logic [2:0] dither_control;                        // err, amp, en
   logic       marker_on_lsb_enable;                  // lsb marker
   logic       link_enable_bit;                       // link enable
   logic [5:0] link_output_mode;                      // output mode

   // reserved bits are not stored, so software that breaks the write-zero
   // convention still reads zero back and changes nothing
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) dither_control <= clr_pkg::RST_DITHER;          // R3
      else if (wr_dither) dither_control <= wdata[clr_pkg::DITH_W-1:0]; // R17
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) marker_on_lsb_enable <= clr_pkg::RST_MARKER;
      else if (wr_lsb) marker_on_lsb_enable <= wdata[clr_pkg::MARKER_BIT];
   end

   // link comes up enabled; software clears it before reconfiguring
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) link_enable_bit <= clr_pkg::RST_LINK_EN;           // R9
      else if (wr_link) link_enable_bit <= wdata[clr_pkg::LINK_EN_BIT]; // R9 R12
   end

   // mode is taken whenever written; quiet-link ordering is up to software
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) link_output_mode <= clr_pkg::RST_MODE;            // R15
      else if (wr_mode) link_output_mode <= wdata[clr_pkg::MODE_W-1:0]; // R15 R16
   end

   // unmapped addresses read zero, reserved bits read zero
   assign rdata = hit_dither ? {5'h00, dither_control} :
                  hit_lsb    ? {7'h00, marker_on_lsb_enable} :
                  hit_link   ? {7'h00, link_enable_bit} :
                  hit_mode   ? {2'h0, link_output_mode} : 8'h00;

   // ***********************************************
   // block controls
   // ***********************************************
   assign o_dither_enable    = dither_control[clr_pkg::DITH_EN_BIT];  // R3
   assign o_dither_amplitude = dither_control[clr_pkg::DITH_AMP_BIT]; // R2
   assign o_dither_rounding  = dither_control[clr_pkg::DITH_ERR_BIT]; // R1
   assign o_link_mode        = link_output_mode;                       // R15
   // link off: held in reset, serializers down, clocks gated
   assign o_link_rst_n       = link_enable_bit;                        // R10
   assign o_serializer_pd    = ~link_enable_bit;                       // R10
   assign o_link_clk_en      = link_enable_bit;                        // R10
   // the marker bit is never announced in the alignment data
   assign o_ila_cs           = clr_pkg::ILA_CS_VALUE;                  // R8

   // ***********************************************
   // sysref synchroniser
   // ***********************************************
   logic sr1, sr2, sr3, sr_q;                         // stages and agreed level
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         sr1 <= 1'b0;
         sr2 <= 1'b0;
         sr3 <= 1'b0;
         sr_q <= 1'b0;
      end else begin
         sr1 <= i_sysref;
         sr2 <= sr1;
         sr3 <= sr2;
         sr_q <= (sr2 == sr3) ? sr3 : sr_q;
      end
   end
   wire sysref_rise = (sr2 == sr3) & sr3 & ~sr_q;     // agreed rising edge

   // ***********************************************
   // multiframe counter
   // ***********************************************
   logic [4:0] lmfc_cnt;                              // frame in multiframe
   logic [4:0] next_lmfc;                             // next count
   // held at zero while the link is off, so a sysref cannot align it
   assign next_lmfc = !link_enable_bit ? 5'h00 :                           // R11
                      sysref_rise ? 5'h00 :
                      (lmfc_cnt == clr_pkg::LMFC_LAST) ? 5'h00 : lmfc_cnt + 5'h01;

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         lmfc_cnt <= 5'h00;
         o_lmfc_boundary <= 1'b0;
      end else begin
         lmfc_cnt <= next_lmfc;
         o_lmfc_boundary <= link_enable_bit & (next_lmfc == 5'h00);        // R11
      end
   end

   // ***********************************************
   // marker insertion
   // ***********************************************
   clr_marker_insert u_marker (
      .i_mclk            (i_mclk),
      .i_rst_n           (rst_n),
      .i_ts_pin          (i_timestamp),
      .i_conv_sample     (i_conv_sample),
      .i_marker_enable   (marker_on_lsb_enable),
      .i_receiver_enable (i_marker_receiver_enable),
      .o_link_sample     (o_link_sample)
   );

   // ***********************************************
   // checks
   // ***********************************************
   sequence s_dither_write;
      wr_stb && addr == clr_pkg::ADDR_DITHER;
   endsequence

   property p_dither_enable;
      @(posedge i_mclk) disable iff (!rst_n)
      s_dither_write |=> o_dither_enable == $past(wdata[0]) ##1 $stable(o_dither_enable) || wr_stb;
   endproperty
   a_dither_enable: assert property (p_dither_enable) else $error("dither enable not taken"); // R3

   property p_dither_amp;
      @(posedge i_mclk) disable iff (!rst_n)
      s_dither_write ##1 1'b1 |-> o_dither_amplitude == $past(wdata[1]);
   endproperty
   a_dither_amp: assert property (p_dither_amp) else $error("dither amplitude not taken"); // R2

   property p_dither_round;
      @(posedge i_mclk) disable iff (!rst_n)
      !wr_stb |=> $stable(o_dither_rounding) && o_dither_rounding == dither_control[2];
   endproperty
   a_dither_round: assert property (p_dither_round) else $error("rounding select moved"); // R1

   property p_link_after_reset;
      @(posedge i_mclk) $rose(rst_n) |-> o_link_rst_n && !o_serializer_pd && o_link_mode == 6'h00;
   endproperty
   a_link_after_reset: assert property (p_link_after_reset) else $error("link not enabled after reset"); // R9

   sequence s_link_off;
      wr_stb && addr == clr_pkg::ADDR_LINK_EN && !wdata[0];
   endsequence

   property p_link_off;
      @(posedge i_mclk) disable iff (!rst_n)
      s_link_off |=> !o_link_rst_n && o_serializer_pd && !o_link_clk_en;
   endproperty
   a_link_off: assert property (p_link_off) else $error("link not shut down"); // R10

   property p_lmfc_held;
      @(posedge i_mclk) disable iff (!rst_n)
      !link_enable_bit [*2] |-> lmfc_cnt == 5'h00 && !o_lmfc_boundary;
   endproperty
   a_lmfc_held: assert property (p_lmfc_held) else $error("multiframe counter ran while off"); // R11

   property p_mode_write;
      @(posedge i_mclk) disable iff (!rst_n)
      wr_stb && addr == clr_pkg::ADDR_LINK_MODE |=> o_link_mode == $past(wdata[5:0]);
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode not taken"); // R15

   property p_ila_cs;
      @(posedge i_mclk) disable iff (!rst_n)
      marker_on_lsb_enable |-> o_ila_cs == 2'h0;
   endproperty
   a_ila_cs: assert property (p_ila_cs) else $error("control bits advertised"); // R8
endmodule

/* sim/converter_link_control_regs_tb.sv */
// self-checking bench for the converter link control register bank
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module converter_link_control_regs_tb;
   logic        i_mclk = 0, i_resetn = 0, i_sclk = 0, i_scs_n = 1, i_sdi = 0;
   logic        i_sysref = 0, i_timestamp = 0, i_marker_receiver_enable = 0;
   logic [11:0] i_conv_sample = 12'h000;
   logic        o_sdo, o_sdo_oe, o_dither_enable, o_dither_amplitude, o_dither_rounding;
   logic        o_link_rst_n, o_serializer_pd, o_link_clk_en, o_lmfc_boundary;
   logic [5:0]  o_link_mode;
   logic [1:0]  o_ila_cs;
   logic [15:0] o_link_sample;
   logic [7:0]  rd;
   logic        oe;
   int          fail_count = 0, checked = 0, cyc = 0, n;
   clr_top uut (.*);
   initial forever #2.5 i_mclk = ~i_mclk;
   // hang guard: a full run needs about 6200 cycles
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("fail_count %0d checked %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one 24-bit frame; each sclk phase held 8 cycles, read bits sampled before each rise
   task automatic xfer(input logic r, input logic [14:0] a, input logic [7:0] d);
      logic [23:0] f;
      f = {r, a, d};
      @(negedge i_mclk) i_scs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         i_sdi = f[i];
         i_sclk = 1'b0;
         repeat (8) @(negedge i_mclk);
         if (i < 8) rd[i] = o_sdo;
         if (i == 7) oe = o_sdo_oe;
         i_sclk = 1'b1;
         repeat (8) @(negedge i_mclk);
      end
      i_sclk = 1'b0;
      repeat (8) @(negedge i_mclk);
      i_scs_n = 1'b1;
      repeat (8) @(negedge i_mclk);
   endtask
   task automatic count_pulses();
      n = 0;
      repeat (64) @(negedge i_mclk) n += (o_lmfc_boundary === 1'b1);
   endtask
   task automatic t_reset();
      `CHK({o_dither_rounding, o_dither_amplitude, o_dither_enable}, 3'h0)
      `CHK({o_link_rst_n, o_serializer_pd, o_link_clk_en}, 3'h5)
      `CHK(o_link_mode, 6'h00)
      `CHK(o_ila_cs, 2'h0)
      `CHK(o_sdo_oe, 1'b0)
      xfer(1'b1, clr_pkg::ADDR_LINK_EN, 8'h00);
      `CHK(rd, 8'h01)
      `CHK(oe, 1'b1)
      xfer(1'b1, clr_pkg::ADDR_LSB_CTRL, 8'h00);
      `CHK(rd, 8'h00)
   endtask
   task automatic t_dither();
      for (int k = 0; k < 3; k++) begin
         xfer(1'b0, clr_pkg::ADDR_DITHER, 8'h01 << k);
         `CHK({o_dither_rounding, o_dither_amplitude, o_dither_enable}, 3'h1 << k)
      end
      xfer(1'b0, clr_pkg::ADDR_DITHER, 8'h07);
      xfer(1'b1, clr_pkg::ADDR_DITHER, 8'h00);
      `CHK(rd, 8'h07)
      xfer(1'b0, 15'h0123, 8'h5a);
      xfer(1'b1, 15'h0123, 8'h00);
      `CHK(rd, 8'h00)
   endtask
   // link off must also silence the multiframe counter against sysref
   task automatic t_link();
      xfer(1'b0, clr_pkg::ADDR_LINK_EN, 8'h00);
      `CHK({o_link_rst_n, o_serializer_pd, o_link_clk_en}, 3'h2)
      // mode only changes while the link is quiet, reserved bits left zero
      xfer(1'b0, clr_pkg::ADDR_LINK_MODE, 8'h3f);
      `CHK(o_link_mode, 6'h3f)
      xfer(1'b1, clr_pkg::ADDR_LINK_MODE, 8'h00);
      `CHK(rd, 8'h3f)
      i_sysref = 1'b1;
      count_pulses();
      i_sysref = 1'b0;
      `CHK(n, 0)
      xfer(1'b0, clr_pkg::ADDR_LINK_EN, 8'h01);
      count_pulses();
      `CHK(n, 2)
   endtask
   // marker sits below the msb-aligned sample, so the sample lsb survives
   task automatic t_marker();
      i_conv_sample = 12'h5a5;
      i_timestamp = 1'b1;
      i_marker_receiver_enable = 1'b1;
      xfer(1'b0, clr_pkg::ADDR_LSB_CTRL, 8'h01);
      `CHK(o_link_sample, 16'h5a51)
      i_conv_sample = 12'h123;
      i_timestamp = 1'b0;
      repeat (4) @(negedge i_mclk);
      `CHK(o_link_sample, 16'h5a51)
      repeat (3) @(negedge i_mclk);
      `CHK(o_link_sample, 16'h1230)
      i_timestamp = 1'b1;
      xfer(1'b0, clr_pkg::ADDR_LSB_CTRL, 8'h00);
      `CHK(o_link_sample, 16'h1230)
   endtask
   initial begin
      repeat (12) @(negedge i_mclk);
      i_resetn = 1'b1;
      repeat (4) @(negedge i_mclk);
      t_reset();
      t_dither();
      t_link();
      t_marker();
      wrap_up();
   end
endmodule
